// File: host_buffer_port.sv
// host-side buffer interface: data buffers, status, flag and dma pins
// Function
// R1 - host accesses act only while chip select (or dma ack) asserted
// R2 - host read returns output buffer or status register
// R3 - write with select low clears command flag, high sets it
// R4 - host write captures data or command byte into input buffer
// R5 - one instruction-cycle strobe pulse per internal cycle
// R6 - 8-bit data bus drivers off unless delivering read data
// R7 - reset clears status flip-flops and program counter
// R8 - separate input and output data buffers
// R9 - status move copies accumulator bits 4-7, bits 0-3 kept
// R10 - flags update after trailing edge of read or write strobe
// R11 - internal status updates held off while host reads status
// R12 - flag pins are port pins until flag-enable executes
// R13 - flag pin a: one outputs output-full, zero forces low
// R14 - flag pin b: one outputs inverted input-full, zero forces low
// R15 - dma pins are port pins until dma-enable executes
// R16 - in dma mode writing one to request bit asserts request
// R17 - request cleared by acked read/write or dma-enable
// R18 - in dma mode ack pin acts as chip select for buffers
// R19 - reset passes a two-stage synchroniser
// R20 - status bits: 0 out-full, 1 in-full, 2 user flag, 3 command
// R21 - out-full set on load, cleared by data read; in-full mirror
`timescale 1ns/1ns
module host_buffer_port
  import host_port_pkg::*;
#(
  parameter int DIV       = CYCLE_DIV,
  parameter int OUT_DEPTH = FIFO_DEPTH
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              cs_n_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic              cmd_data_select_i,
  input  wire logic [DATA_W-1:0] db_i,
  output logic      [DATA_W-1:0] db_o,
  output logic                   db_oe_o,
  input  wire core_cmd_t         core_i,
  input  wire logic              out_valid_i,
  output logic                   out_ready_o,
  output logic      [DATA_W-1:0] in_data_o,
  output logic                   in_cmd_o,
  output logic      [DATA_W-1:0] host_status_o,
  input  wire logic [3:0]        port_pin_i,
  output logic      [3:0]        port_pin_o,
  output logic      [3:0]        port_pin_oe_o,
  output logic                   cycle_strobe_o,
  output logic                   core_rst_o,
  output logic      [10:0]       pc_o
);
  logic [1:0]        rst_sync_q;
  logic              rst;
  logic [DATA_W-1:0] sts_q, sts_d, obuf_q, obuf_d, ibuf_q, ibuf_d;
  logic [DATA_W-1:0] db_q, db_d;
  logic [3:0]        port_q, port_d;
  logic              flags_en_q, flags_en_d, dma_en_q, dma_en_d;
  logic              dreq_q, dreq_d, oe_q, oe_d;
  logic [4:0]        div_q, div_d;
  logic              strobe_q, strobe_d;
  logic [10:0]       pc_q, pc_d;
  bus_state_t        st_q, st_d;
  logic              sel_cmd_q, sel_cmd_d, was_dma_q, was_dma_d;
  logic              sel, ack, rd_end, wr_end, rd_sts;
  logic              f_valid, f_ready, f_pop;
  logic [DATA_W-1:0] f_data;
  host_req_t         req;

  // two-stage reset synchroniser; stage one feeds only stage two
  always_ff @(posedge clk_i) begin
    rst_sync_q <= {rst_sync_q[0], sys_rst_i}; // R19
  end
  assign rst        = rst_sync_q[1];
  assign core_rst_o = rst;

  // core-loaded bytes queue here before the output buffer
  byte_fifo #(.WIDTH(DATA_W), .DEPTH(OUT_DEPTH)) u_out_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst),
    .in_valid_i  (out_valid_i && core_i.out_load),
    .in_ready_o  (f_ready),
    .in_data_i   (core_i.out_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_data)
  );
  assign out_ready_o = f_ready;

  // chip select, with dma ack doubling as select in dma mode
  always_comb begin
    ack         = dma_en_q && !port_pin_i[PIN_DMA_ACK];
    sel         = !cs_n_i || ack; // R1 R18
    req.rd      = sel && !rd_n_i;
    req.wr      = sel && !wr_n_i;
    req.sel_cmd = cmd_data_select_i;
    req.data    = db_i;
  end

  // strobe tracker: flags move only on the trailing edge
  always_comb begin
    st_d      = st_q;
    sel_cmd_d = sel_cmd_q;
    was_dma_d = was_dma_q;
    rd_end    = 1'b0;
    wr_end    = 1'b0;
    case (st_q)
      BUS_IDLE: begin
        if (req.rd) st_d = BUS_RD;
        else if (req.wr) st_d = BUS_WR;
        sel_cmd_d = req.sel_cmd;
        was_dma_d = ack;
      end
      BUS_RD: if (rd_n_i) begin
        rd_end = 1'b1; // R10
        st_d   = BUS_IDLE;
      end
      BUS_WR: if (wr_n_i) begin
        wr_end = 1'b1; // R10
        st_d   = BUS_IDLE;
      end
      default: st_d = BUS_IDLE;
    endcase
  end
  assign rd_sts = (st_q == BUS_RD) && sel_cmd_q;

  // buffers, status and pin mode state
  always_comb begin
    sts_d      = sts_q;
    obuf_d     = obuf_q;
    ibuf_d     = ibuf_q;
    db_d       = db_q;
    oe_d       = 1'b0;
    port_d     = port_q;
    flags_en_d = flags_en_q || core_i.en_flags; // R12
    dma_en_d   = dma_en_q || core_i.en_dma; // R15
    dreq_d     = dreq_q;
    f_pop      = 1'b0;
    // drivers let go on the edge that sees the strobe released
    if ((st_q == BUS_RD && !rd_n_i) || (st_q == BUS_IDLE && req.rd)) begin
      oe_d = 1'b1; // R6
      db_d = (st_q == BUS_IDLE ? req.sel_cmd : sel_cmd_q)
             ? sts_q : obuf_q; // R2
    end
    if (st_q == BUS_IDLE && req.wr) ibuf_d = req.data; // R4 R8
    if (core_i.port_wr) port_d = core_i.port_data;
    // internal updates are skipped while the host reads status
    if (!rd_sts) begin // R11
      if (core_i.in_take) sts_d[ST_IFULL_BIT] = 1'b0; // R21
      if (!sts_q[ST_OFULL_BIT] && f_valid) begin
        obuf_d              = f_data; // R8
        sts_d[ST_OFULL_BIT] = 1'b1; // R21
        f_pop               = 1'b1;
      end
      if (core_i.sts_move)
        sts_d[ST_USER_HI:ST_USER_LO] =
          core_i.acc[ST_USER_HI:ST_USER_LO]; // R9
      if (core_i.uf0_set) sts_d[ST_UF0_BIT] = 1'b1;
      if (core_i.uf0_clr) sts_d[ST_UF0_BIT] = 1'b0;
    end
    // host events last so they beat same-cycle core updates
    if (rd_end && !sel_cmd_q) sts_d[ST_OFULL_BIT] = 1'b0; // R21
    if (wr_end) begin
      sts_d[ST_IFULL_BIT] = 1'b1; // R21
      sts_d[ST_CMD_BIT]   = sel_cmd_q; // R3
    end
    // a request written as an acked transfer ends is kept, not lost
    if (((rd_end || wr_end) && was_dma_q) || core_i.en_dma)
      dreq_d = 1'b0; // R17
    if (dma_en_q && core_i.port_wr && core_i.port_data[PIN_DMA_REQ])
      dreq_d = 1'b1; // R16
  end

  // instruction cycle divider and program counter
  always_comb begin
    div_d    = (div_q == 5'(DIV - 1)) ? '0 : div_q + 1'b1;
    strobe_d = (div_q == 5'(DIV - 1)); // R5
    pc_d     = strobe_d ? pc_q + 1'b1 : pc_q;
  end

  // state registers except the reset synchroniser; reset clears status and counter
  always_ff @(posedge clk_i) begin
    if (rst) begin
      sts_q      <= STATUS_RST; // R7
      pc_q       <= '0; // R7
      obuf_q     <= '0;
      ibuf_q     <= '0;
      db_q       <= '0;
      oe_q       <= 1'b0;
      port_q     <= PORT_RST;
      flags_en_q <= 1'b0;
      dma_en_q   <= 1'b0;
      dreq_q     <= 1'b0;
      div_q      <= '0;
      strobe_q   <= 1'b0;
      st_q       <= BUS_IDLE;
      sel_cmd_q  <= 1'b0;
      was_dma_q  <= 1'b0;
    end else begin
      sts_q      <= sts_d;
      pc_q       <= pc_d;
      obuf_q     <= obuf_d;
      ibuf_q     <= ibuf_d;
      db_q       <= db_d;
      oe_q       <= oe_d;
      port_q     <= port_d;
      flags_en_q <= flags_en_d;
      dma_en_q   <= dma_en_d;
      dreq_q     <= dreq_d;
      div_q      <= div_d;
      strobe_q   <= strobe_d;
      st_q       <= st_d;
      sel_cmd_q  <= sel_cmd_d;
      was_dma_q  <= was_dma_d;
    end
  end

  // pin muxing: quasi-bidirectional port bits drive low only
  always_comb begin
    port_pin_o    = '0;
    port_pin_oe_o = ~port_q;
    if (flags_en_q) begin
      port_pin_o[PIN_FLAG_A]    = port_q[PIN_FLAG_A] &&
                                  sts_q[ST_OFULL_BIT]; // R13
      port_pin_oe_o[PIN_FLAG_A] = 1'b1;
      port_pin_o[PIN_FLAG_B]    = port_q[PIN_FLAG_B] &&
                                  !sts_q[ST_IFULL_BIT]; // R14
      port_pin_oe_o[PIN_FLAG_B] = 1'b1;
    end
    if (dma_en_q) begin
      port_pin_o[PIN_DMA_REQ]    = dreq_q; // R16
      port_pin_oe_o[PIN_DMA_REQ] = 1'b1;
      port_pin_oe_o[PIN_DMA_ACK] = 1'b0; // R18
    end
  end

  assign db_o           = db_q;
  assign db_oe_o        = oe_q; // R6
  assign in_data_o      = ibuf_q;
  assign in_cmd_o       = sts_q[ST_CMD_BIT];
  assign host_status_o  = sts_q; // R20
  assign cycle_strobe_o = strobe_q;
  assign pc_o           = pc_q;
endmodule : host_buffer_port

// File: host_port_pkg.sv
// shared constants and carrier types for the slave host buffer interface
package host_port_pkg;
  localparam int          DATA_W        = 8;
  // status register field positions
  localparam int          ST_OFULL_BIT  = 0;
  localparam int          ST_IFULL_BIT  = 1;
  localparam int          ST_UF0_BIT    = 2;
  localparam int          ST_CMD_BIT    = 3;
  localparam int          ST_USER_LO    = 4;
  localparam int          ST_USER_HI    = 7;
  // port-2 upper pin positions within the 4-bit group
  localparam int          PIN_FLAG_A    = 0;
  localparam int          PIN_FLAG_B    = 1;
  localparam int          PIN_DMA_REQ   = 2;
  localparam int          PIN_DMA_ACK   = 3;
  localparam logic [3:0]  PORT_RST      = 4'hF;
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  localparam int          CYCLE_DIV     = 15;
  localparam int          FIFO_DEPTH    = 16;

  // host strobe decode after chip select gating
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       sel_cmd;
    logic [7:0] data;
  } host_req_t;

  // internal core-side command group
  typedef struct packed {
    logic       out_load;
    logic [7:0] out_data;
    logic       in_take;
    logic       sts_move;
    logic [7:0] acc;
    logic       uf0_set;
    logic       uf0_clr;
    logic       en_flags;
    logic       en_dma;
    logic       port_wr;
    logic [3:0] port_data;
  } core_cmd_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD   = 2'b01,
    BUS_WR   = 2'b10
  } bus_state_t;
endpackage : host_port_pkg

// File: byte_fifo.sv
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic             push, pop;

  // honest full/empty from extended pointers
  always_comb begin
    in_ready_o  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    out_valid_o = wp_q != rp_q;
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wp_d        = push ? wp_q + 1'b1 : wp_q;
    rp_d        = pop ? rp_q + 1'b1 : rp_q;
    out_data_o  = mem_q[rp_q[AW-1:0]];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) mem_q[wp_q[AW-1:0]] <= in_data_i;
  end
endmodule : byte_fifo

// File: host_port_checker.sv
// assertion checker for the host buffer port
`timescale 1ns/1ns
module host_port_checker
  import host_port_pkg::*;
#(
  parameter int DIV = CYCLE_DIV
) (
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              cs_n_i,
  input wire logic              rd_n_i,
  input wire logic              wr_n_i,
  input wire logic              cmd_data_select_i,
  input wire logic [3:0]        port_pin_i,
  input wire logic              db_oe_o,
  input wire logic              in_cmd_o,
  input wire logic [DATA_W-1:0] host_status_o,
  input wire logic              cycle_strobe_o,
  input wire logic [3:0]        port_pin_oe_o,
  input wire logic [10:0]       pc_o,
  input wire logic              core_rst_o
);
  localparam int GAP = DIV - 1;
  logic sts_rd;
  // host status read under way
  assign sts_rd = !cs_n_i && !rd_n_i && cmd_data_select_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  oe_cause_a: assert property ($rose(db_oe_o) |-> !$past(rd_n_i))
    else $error("bus driven without a read");
  oe_drop_a: assert property (rd_n_i |=> !db_oe_o)
    else $error("bus still driven after read");
  no_sel_a: assert property (cs_n_i && port_pin_i[3] |=> !db_oe_o)
    else $error("bus driven while unselected");
  cmd_flag_a: assert property ($rose(wr_n_i) && !$past(cs_n_i) |=>
    in_cmd_o == $past(cmd_data_select_i, 2))
    else $error("command flag wrong");
  in_full_set_a: assert property ($rose(wr_n_i) && !$past(cs_n_i) |=>
    host_status_o[ST_IFULL_BIT])
    else $error("input full not set");
  in_full_wait_a: assert property (
    !wr_n_i && !host_status_o[ST_IFULL_BIT] |=>
    !host_status_o[ST_IFULL_BIT])
    else $error("input full before trailing edge");
  sts_lock_a: assert property (sts_rd && $past(sts_rd) &&
    $past(sts_rd, 2) |-> $stable(host_status_o))
    else $error("status changed during read");
  strobe_gap_a: assert property (cycle_strobe_o |=>
    !cycle_strobe_o ##GAP cycle_strobe_o)
    else $error("cycle strobe spacing wrong");
  rst_state_a: assert property (disable iff (1'b0)
    sys_rst_i [*3] |=> host_status_o == STATUS_RST && pc_o == 11'h000 &&
    !db_oe_o && port_pin_oe_o == 4'h0 && core_rst_o)
    else $error("reset state wrong");
  // internal reset trails the pin by the two synchroniser stages
  rst_sync_a: assert property ($fell(sys_rst_i) |->
    core_rst_o ##1 core_rst_o ##1 !core_rst_o)
    else $error("reset release timing wrong");
endmodule : host_port_checker

bind host_buffer_port host_port_checker #(.DIV(DIV)) i_host_port_checker (.*);

// File: host_model.sv
// host processor model: strobed reads and writes on the buffer port
`timescale 1ns/1ns
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            cmd_sel_o,
  output logic            ack_n_o,
  output logic [7:0]      wdata_o
);
  // idle: strobes high, nothing selected
  initial begin
    {cs_n_o, rd_n_o, wr_n_o, ack_n_o, cmd_sel_o} = 5'h1E;
    wdata_o = 8'h5A;
  end
  // sel 0 chip select, 1 dma ack, 2 none; held until strobe released
  task automatic xfer(input logic rd, input logic [1:0] sel,
                      input logic cmd, input logic [7:0] wd,
                      output logic [7:0] rq);
    @(posedge clk_i);
    cs_n_o  <= (sel != 2'h0);
    ack_n_o <= (sel != 2'h1);
    cmd_sel_o <= cmd;
    wdata_o <= wd;
    rd_n_o  <= !rd;
    wr_n_o  <= rd;
    repeat (3) @(posedge clk_i);
    rq = rdata_i;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    @(posedge clk_i);
    cs_n_o  <= 1'b1;
    ack_n_o <= 1'b1;
    wdata_o <= ~wd; // released bus keeps no stale byte
    @(posedge clk_i);
    #1;
  endtask : xfer
endmodule : host_model

// File: host_buffer_port_test.sv
// testbench for the host buffer port
`timescale 1ns/1ns
module host_buffer_port_test;
  import host_port_pkg::*;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       out_valid_i = 1'b0;
  logic       cs_n, rd_n, wr_n, cmd_sel, ack_n, db_oe, out_ready, in_cmd;
  logic [7:0] wd, db, in_data, status, rq;
  logic [3:0] pin_o, pin_oe, pin;
  core_cmd_t  core_i = '0;
  int         mismatches = 0;
  int         checks_done = 0;
  int         n = 0;

  always #25 clk_i = !clk_i;
  // port pins pull up; ack pin follows the dma controller
  assign pin = (pin_oe & pin_o) | (~pin_oe & {ack_n, 3'h7});

  host_buffer_port #(.DIV(4)) i_host_buffer_port (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .cmd_data_select_i(cmd_sel), .db_i(wd), .db_o(db),
    .db_oe_o(db_oe), .core_i(core_i), .out_valid_i(out_valid_i),
    .out_ready_o(out_ready), .in_data_o(in_data), .in_cmd_o(in_cmd),
    .host_status_o(status), .port_pin_i(pin), .port_pin_o(pin_o),
    .port_pin_oe_o(pin_oe), .cycle_strobe_o(), .core_rst_o(), .pc_o());
  host_model i_host_model (.clk_i(clk_i), .rdata_i(db_oe ? db : 8'hxx),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .cmd_sel_o(cmd_sel),
    .ack_n_o(ack_n), .wdata_o(wd));

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  // one-cycle core command pulse, then time for it to land
  task automatic core(input core_cmd_t c);
    @(posedge clk_i);
    core_i      <= c;
    out_valid_i <= c.out_load;
    @(posedge clk_i);
    core_i      <= '0;
    out_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : core

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // watchdog: a hung sequence is a failure
  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("reset status", STATUS_RST, status);
    i_host_model.xfer(1'b0, 2'h0, 1'b0, 8'h3C, rq);
    chk("data byte", 8'h3C, in_data);
    chk("status data", 8'h02, status);
    i_host_model.xfer(1'b0, 2'h0, 1'b1, 8'hC3, rq);
    chk("cmd flag", 8'h01, {7'h0, in_cmd});
    chk("status cmd", 8'h0A, status);
    i_host_model.xfer(1'b0, 2'h2, 1'b0, 8'h55, rq);
    chk("unselected", 8'hC3, in_data);
    // an unselected read must leave the bus undriven
    i_host_model.xfer(1'b1, 2'h2, 1'b0, 8'h00, rq);
    chk("unselected read", 8'hxx, rq);
    core('{in_take: 1'h1, sts_move: 1'h1, acc: 8'hA5, uf0_set: 1'h1,
      default: '0});
    chk("user bits", 8'hAC, status);
    // a clear arriving mid status read is dropped, not queued
    fork
      i_host_model.xfer(1'b1, 2'h0, 1'b1, 8'h00, rq);
      begin
        @(posedge clk_i);
        core('{uf0_clr: 1'h1, default: '0});
      end
    join
    chk("status read", 8'hAC, rq);
    chk("lockout", 8'hAC, status);
    core('{port_wr: 1'h1, port_data: 4'hF, default: '0});
    chk("port pins", 8'h0F, {4'h0, pin});
    core('{en_flags: 1'h1, default: '0});
    chk("flags idle", 8'h0E, {4'h0, pin});
    i_host_model.xfer(1'b0, 2'h0, 1'b0, 8'h11, rq);
    core('{out_load: 1'h1, out_data: 8'h96, default: '0});
    chk("flags full", 8'h0D, {4'h0, pin});
    chk("input kept", 8'h11, in_data);
    i_host_model.xfer(1'b1, 2'h0, 1'b0, 8'h00, rq);
    chk("data read", 8'h96, rq);
    chk("out cleared", 8'h00, {7'h0, status[ST_OFULL_BIT]});
    core('{en_dma: 1'h1, default: '0});
    chk("req idle", 8'h00, {7'h0, pin[PIN_DMA_REQ]});
    core('{port_wr: 1'h1, port_data: 4'hF, default: '0});
    chk("req raised", 8'h01, {7'h0, pin[PIN_DMA_REQ]});
    core('{out_load: 1'h1, out_data: 8'h69, default: '0});
    i_host_model.xfer(1'b1, 2'h1, 1'b0, 8'h00, rq);
    chk("dma read", 8'h69, rq);
    chk("req cleared", 8'h00, {7'h0, pin[PIN_DMA_REQ]});
    // acked write also drops the request
    core('{port_wr: 1'h1, port_data: 4'hF, default: '0});
    chk("req again", 8'h01, {7'h0, pin[PIN_DMA_REQ]});
    i_host_model.xfer(1'b0, 2'h1, 1'b0, 8'h77, rq);
    chk("dma write", 8'h77, in_data);
    chk("req write clr", 8'h00, {7'h0, pin[PIN_DMA_REQ]});
    // fill until refused: fifo words plus the output buffer
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_i);
      core_i      <= '{out_load: 1'h1, out_data: n[7:0], default: '0};
      out_valid_i <= 1'b1;
      @(negedge clk_i);
      if (out_ready)
        n++;
    end
    @(posedge clk_i);
    core_i      <= '0;
    out_valid_i <= 1'b0;
    #1;
    chk("accepted", 8'h11, n[7:0]);
    for (int k = 0; k < 17; k++) begin
      repeat (2) @(posedge clk_i);
      i_host_model.xfer(1'b1, 2'h0, 1'b0, 8'h00, rq);
      chk("drained", k[7:0], rq);
    end
    repeat (3) @(posedge clk_i);
    #1;
    chk("empty", 8'h00, {7'h0, status[ST_OFULL_BIT]});
    complete_run();
  end
endmodule : host_buffer_port_test
